// >>> pkg/pfc_pwm_defs.vh
`ifndef PFC_PWM_DEFS_VH
`define PFC_PWM_DEFS_VH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
// cycle counts at the 20 MHz clock, sized to the timer width so that
// no parameter or compare silently drops bits
// brownout debounce, 1000 ms
`define BROWNOUT_CYCLES 25'h1312D00
// line-sag delay, 33 ms
`define SAG_CYCLES 25'hA1220
// counter width, covers the brownout count
`define TIMER_W 25

// ----------------------------------------------------------------------------
// forward-stage sequencing states
// ----------------------------------------------------------------------------
`define FWD_INHIBIT 2'h0
`define FWD_SOFT 2'h1
`define FWD_RUN 2'h2

// ----------------------------------------------------------------------------
// bit positions in the synchronised flag vector
// ----------------------------------------------------------------------------
`define FLAG_N 13
`define F_DISCHARGE 0
`define F_BOOST_MOD 1
`define F_BOOST_ILIM 2
`define F_RMS_LOW 3
`define F_RMS_HIGH 4
`define F_RMS_SAG 5
`define F_FB_OFF 6
`define F_FB_GOOD 7
`define F_SS_REL 8
`define F_FWD_OFFS 9
`define F_FWD_CAP 10
`define F_FWD_MOD 11
`define F_ALT_VAR 12

`endif

// >>> verilog/low_line_timer.v
`timescale 1ns/1ps
`include "pfc_pwm_defs.vh"

// ----------------------------------------------------------------------------
// low-line delay timer
// ----------------------------------------------------------------------------
module low_line_timer #(
  parameter [`TIMER_W-1:0] CYCLES = `SAG_CYCLES
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_cond,
  output reg o_expired
);

  reg [`TIMER_W-1:0] cnt_q;

  // counts while the condition holds, back to zero the moment it clears
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= {`TIMER_W{1'b0}};
      o_expired <= 1'b0;
    end else if (!i_cond) begin
      cnt_q <= {`TIMER_W{1'b0}};
      o_expired <= 1'b0;
    end else if (cnt_q < CYCLES) begin
      cnt_q <= cnt_q + {{(`TIMER_W-1){1'b0}}, 1'b1};
      o_expired <= 1'b0;
    end else begin
      o_expired <= 1'b1; // stays up while the condition lasts
    end
  end

endmodule // low_line_timer

// >>> verilog/pfc_pwm_timing_protection.v
`timescale 1ns/1ps
`include "pfc_pwm_defs.vh"

// Overview of operation
// - base variant: boost and forward stages clocked at oscillator/4 by toggles
// - alternate variant: boost at oscillator/4, forward at oscillator/2
// - forward gate on-time capped at half period by divider outputs
// - boost turn-off aligned with forward turn-on at period start
// - boost gate held off during every oscillator discharge interval
// - boost current limit forces boost gate off until next boost cycle
// - line rms below low brownout threshold shuts boost stage down
// - boost restarts only after line rms rises above high threshold
// - brownout needs low line persisting for the debounce time first
// - forward current cap trip blocks forward gate until next forward cycle
// - forward inhibited until bulk good, then soft-start begins
// - running forward stage stops when boost feedback under off level or on a sag trip
// - forward switching waits for soft-start release comparator
// - forward feedback below offset gives zero forward duty
// - line below sag level longer than sag delay trips sag protection
// - line below sag level with feedback under off level trips at once
// - sag trip stops both stages until line rms above high threshold
// - forward maximum duty slightly below one half, never above
module pfc_pwm_timing_protection #(
  parameter [`TIMER_W-1:0] BROWNOUT_CYCLES = `BROWNOUT_CYCLES,
  parameter [`TIMER_W-1:0] SAG_CYCLES = `SAG_CYCLES
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_timing_network_pin,
  input wire i_boost_mod_on,
  input wire i_boost_current_sense_low,
  input wire i_line_rms_sense_low,
  input wire i_line_rms_sense_high,
  input wire i_line_rms_sense_sag,
  input wire i_boost_feedback_off,
  input wire i_bulk_good_comparator,
  input wire i_soft_start_release,
  input wire i_forward_feedback_above_offset,
  input wire i_forward_current_cap,
  input wire i_forward_mod_trip,
  input wire i_alt_variant,
  output reg o_boost_gate,
  output reg o_forward_gate,
  output reg o_boost_clk,
  output reg o_forward_clk,
  output reg o_boost_running,
  output reg o_forward_soft_start,
  output reg o_forward_running,
  output reg o_sag_tripped
);

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  wire [`FLAG_N-1:0] raw_flags;
  reg [`FLAG_N-1:0] meta_q;
  reg [`FLAG_N-1:0] flag_q;

  assign raw_flags = {i_alt_variant, i_forward_mod_trip, i_forward_current_cap,
                      i_forward_feedback_above_offset, i_soft_start_release,
                      i_bulk_good_comparator, i_boost_feedback_off,
                      i_line_rms_sense_sag, i_line_rms_sense_high,
                      i_line_rms_sense_low, i_boost_current_sense_low,
                      i_boost_mod_on, i_timing_network_pin};

  // two flops per flag; the first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < `FLAG_N; gi = gi + 1) begin : g_sync
      always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          meta_q[gi] <= 1'b0;
          flag_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw_flags[gi];
          flag_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  wire discharge = flag_q[`F_DISCHARGE];
  wire boost_mod = flag_q[`F_BOOST_MOD];
  wire boost_ilim = flag_q[`F_BOOST_ILIM];
  wire rms_low = flag_q[`F_RMS_LOW];
  wire rms_high = flag_q[`F_RMS_HIGH];
  wire rms_sag = flag_q[`F_RMS_SAG];
  wire fb_off = flag_q[`F_FB_OFF];
  wire fb_good = flag_q[`F_FB_GOOD];
  wire ss_rel = flag_q[`F_SS_REL];
  wire fwd_offs = flag_q[`F_FWD_OFFS];
  wire fwd_cap = flag_q[`F_FWD_CAP];
  wire fwd_mod = flag_q[`F_FWD_MOD];
  wire alt_var = flag_q[`F_ALT_VAR];

  // --------------------------------------------------------------------------
  // oscillator tick and toggle divider chain
  // --------------------------------------------------------------------------
  reg disch_prev_q;
  reg tog1_q;
  reg tog2_q;
  wire osc_tick;

  // one oscillator cycle begins at the rising edge of the discharge flag
  assign osc_tick = discharge & ~disch_prev_q;

  // second toggle flips on the falling edge of the first, as in a ripple chain
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      disch_prev_q <= 1'b0;
      tog1_q <= 1'b0;
      tog2_q <= 1'b0;
    end else begin
      disch_prev_q <= discharge;
      if (osc_tick) begin
        tog1_q <= ~tog1_q;
        if (tog1_q) begin
          tog2_q <= ~tog2_q;
        end
      end
    end
  end

  // period boundaries decoded from the divider state before the tick
  wire boost_start = osc_tick & tog1_q & tog2_q;
  wire fwd_start_base = boost_start;
  wire fwd_start_alt = osc_tick & tog1_q;
  wire fwd_start = alt_var ? fwd_start_alt : fwd_start_base;
  // divider edge that opens the second half of the forward period
  wire fwd_half_base = osc_tick & tog1_q & ~tog2_q;
  wire fwd_half_alt = osc_tick & ~tog1_q;
  wire fwd_half = alt_var ? fwd_half_alt : fwd_half_base;

  // divided clocks shown at the pins, low in the first half of a period
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_boost_clk <= 1'b0;
      o_forward_clk <= 1'b0;
    end else begin
      o_boost_clk <= tog2_q;
      o_forward_clk <= alt_var ? tog1_q : tog2_q;
    end
  end

  // --------------------------------------------------------------------------
  // brownout and line-sag supervision
  // --------------------------------------------------------------------------
  reg boost_run_q;
  reg sag_q;
  wire brownout_expired;
  wire sag_expired;
  wire sag_now;

  low_line_timer #(
    .CYCLES(BROWNOUT_CYCLES)
  ) u_brownout_timer (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_cond(rms_low & boost_run_q),
    .o_expired(brownout_expired)
  );

  low_line_timer #(
    .CYCLES(SAG_CYCLES)
  ) u_sag_timer (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_cond(rms_sag & ~sag_q),
    .o_expired(sag_expired)
  );

  // either the long sag or a sag with a collapsed bulk trips protection
  assign sag_now = sag_expired | (rms_sag & fb_off);

  // a trip in the same cycle as the high-line release wins, staying latched
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sag_q <= 1'b0;
    end else if (sag_now) begin
      sag_q <= 1'b1;
    end else if (rms_high) begin
      sag_q <= 1'b0;
    end
  end

  // boost stays off after power-up until the line is proven high
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      boost_run_q <= 1'b0;
    end else if (brownout_expired | sag_now | sag_q) begin
      boost_run_q <= 1'b0;
    end else if (rms_high) begin
      boost_run_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // forward-stage sequencing
  // --------------------------------------------------------------------------
  reg [1:0] fwd_state_q;
  reg [1:0] fwd_state_d;

  // hysteresis between bulk-good and the lower off level
  always @* begin
    fwd_state_d = fwd_state_q;
    case (fwd_state_q)
      `FWD_INHIBIT: begin
        if (fb_good & ~sag_q & ~sag_now) begin
          fwd_state_d = `FWD_SOFT;
        end
      end
      `FWD_SOFT: begin
        if (sag_q | sag_now | fb_off) begin
          fwd_state_d = `FWD_INHIBIT;
        end else if (ss_rel) begin
          fwd_state_d = `FWD_RUN;
        end
      end
      `FWD_RUN: begin
        if (sag_q | sag_now | fb_off) begin
          fwd_state_d = `FWD_INHIBIT;
        end
      end
      default: begin
        fwd_state_d = `FWD_INHIBIT;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fwd_state_q <= `FWD_INHIBIT;
    end else begin
      fwd_state_q <= fwd_state_d;
    end
  end

  // --------------------------------------------------------------------------
  // cycle-by-cycle limit latches
  // --------------------------------------------------------------------------
  reg boost_lim_q;
  reg fwd_lim_q;

  // a limit arriving on the very period boundary is kept, not lost
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      boost_lim_q <= 1'b0;
      fwd_lim_q <= 1'b0;
    end else begin
      if (boost_ilim) begin
        boost_lim_q <= 1'b1;
      end else if (boost_start) begin
        boost_lim_q <= 1'b0;
      end
      if (fwd_cap) begin
        fwd_lim_q <= 1'b1;
      end else if (fwd_start) begin
        fwd_lim_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // gate generation
  // --------------------------------------------------------------------------
  reg fwd_arm_q;
  wire boost_ok;
  wire fwd_ok;

  assign boost_ok = boost_run_q & ~sag_q & ~boost_lim_q & ~boost_ilim;
  assign fwd_ok = (fwd_state_q == `FWD_RUN) & ~sag_q & ~fwd_lim_q &
                  ~fwd_cap & fwd_offs;

  // forward turn-on waits one clock after the boundary, trading a 50 ns
  // sliver of duty for a hard guarantee of staying under one half
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fwd_arm_q <= 1'b0;
    end else begin
      fwd_arm_q <= fwd_start;
    end
  end

  // leading-edge boost: on by modulator after discharge, off at period end
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_boost_gate <= 1'b0;
    end else if (!boost_ok) begin
      o_boost_gate <= 1'b0;
    end else if (boost_start | discharge) begin
      o_boost_gate <= 1'b0;
    end else if (boost_mod) begin
      o_boost_gate <= 1'b1;
    end
  end

  // trailing-edge forward: on at period start, off by modulator or half
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_forward_gate <= 1'b0;
    end else if (!fwd_ok) begin
      o_forward_gate <= 1'b0;
    end else if (fwd_half | fwd_mod) begin
      o_forward_gate <= 1'b0;
    end else if (fwd_arm_q) begin
      o_forward_gate <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // status outputs
  // --------------------------------------------------------------------------
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_boost_running <= 1'b0;
      o_forward_soft_start <= 1'b0;
      o_forward_running <= 1'b0;
      o_sag_tripped <= 1'b0;
    end else begin
      o_boost_running <= boost_run_q;
      o_forward_soft_start <= (fwd_state_q != `FWD_INHIBIT);
      o_forward_running <= (fwd_state_q == `FWD_RUN);
      o_sag_tripped <= sag_q;
    end
  end

endmodule // pfc_pwm_timing_protection

// >>> testbench/pfc_pwm_checker.sv
`timescale 1ns/1ps
module pfc_pwm_checker (
  input wire i_clk,
  input wire i_resetn,
  input wire i_timing_network_pin,
  input wire i_boost_current_sense_low,
  input wire i_line_rms_sense_sag,
  input wire i_boost_feedback_off,
  input wire i_forward_feedback_above_offset,
  input wire i_forward_current_cap,
  input wire i_alt_variant,
  input wire o_boost_gate,
  input wire o_forward_gate,
  input wire o_boost_clk,
  input wire o_forward_clk,
  input wire o_boost_running,
  input wire o_forward_running,
  input wire o_sag_tripped
);
  reg [3:0] rise_q;
  reg pin_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ramps seen inside one forward pulse; sync delay leaves 3 clk slack
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rise_q <= 4'h0;
      pin_q <= 1'b0;
    end else begin
      pin_q <= i_timing_network_pin;
      if (!o_forward_gate)
        rise_q <= 4'h0;
      else if (i_timing_network_pin && !pin_q)
        rise_q <= rise_q + 4'h1;
    end
  end
  // ----------------------------------------
  // gate and state relations
  // ----------------------------------------
  property p_dead;
    i_timing_network_pin [*2] |-> ##2 !o_boost_gate;
  endproperty
  a_dead: assert property (p_dead)
    else $error("boost gate on in dead time");
  property p_blim;
    i_boost_current_sense_low [*4] |=> !o_boost_gate;
  endproperty
  a_blim: assert property (p_blim)
    else $error("boost gate on past limit");
  property p_fcap;
    i_forward_current_cap [*4] |=> !o_forward_gate;
  endproperty
  a_fcap: assert property (p_fcap)
    else $error("forward gate on past cap");
  property p_offs;
    !i_forward_feedback_above_offset [*4] |=> !o_forward_gate;
  endproperty
  a_offs: assert property (p_offs)
    else $error("forward gate on below offset");
  property p_sag2;
    (i_line_rms_sense_sag && i_boost_feedback_off) [*4] |=> o_sag_tripped;
  endproperty
  a_sag2: assert property (p_sag2)
    else $error("sag with low feedback not tripped");
  property p_stop;
    o_sag_tripped && $past(o_sag_tripped) |->
      !o_boost_running && !o_forward_running;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stage running while sag tripped");
  property p_duty;
    o_forward_gate |-> rise_q <= (i_alt_variant ? 4'h1 : 4'h2);
  endproperty
  a_duty: assert property (p_duty)
    else $error("forward pulse over half period");
  property p_clk;
    !i_alt_variant |-> o_forward_clk == o_boost_clk;
  endproperty
  a_clk: assert property (p_clk)
    else $error("base variant clocks differ");
endmodule // pfc_pwm_checker

bind pfc_pwm_timing_protection pfc_pwm_checker u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn),
  .i_timing_network_pin(i_timing_network_pin),
  .i_boost_current_sense_low(i_boost_current_sense_low),
  .i_line_rms_sense_sag(i_line_rms_sense_sag),
  .i_boost_feedback_off(i_boost_feedback_off),
  .i_forward_feedback_above_offset(i_forward_feedback_above_offset),
  .i_forward_current_cap(i_forward_current_cap),
  .i_alt_variant(i_alt_variant), .o_boost_gate(o_boost_gate),
  .o_forward_gate(o_forward_gate), .o_boost_clk(o_boost_clk),
  .o_forward_clk(o_forward_clk), .o_boost_running(o_boost_running),
  .o_forward_running(o_forward_running), .o_sag_tripped(o_sag_tripped));

// >>> testbench/stage_model.sv
`timescale 1ns/1ps
module stage_model #(
  parameter OSC = 16
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_forward_gate,
  input wire [7:0] i_trip_at,
  output reg o_timing_network_pin = 1'b0,
  output reg o_forward_mod_trip = 1'b0
);
  reg [7:0] ph_q;
  reg [7:0] on_q;
  // free ramp with a 3 clk discharge; forward ramp trips after i_trip_at
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ph_q <= 8'h00;
      on_q <= 8'h00;
      o_timing_network_pin <= 1'b0;
      o_forward_mod_trip <= 1'b0;
    end else begin
      ph_q <= (ph_q == OSC - 1) ? 8'h00 : ph_q + 8'h01;
      o_timing_network_pin <= ph_q >= OSC - 3;
      on_q <= i_forward_gate ? on_q + 8'h01 : 8'h00;
      o_forward_mod_trip <= i_forward_gate && on_q >= i_trip_at;
    end
  end
endmodule // stage_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam OSC = 16;
  reg i_clk = 1'b0;
  reg i_resetn = 1'b0;
  reg mod_on = 1'b0, ilim = 1'b0, rlow = 1'b0, rhigh = 1'b0;
  reg rsag = 1'b0, fboff = 1'b0, good = 1'b0, ssr = 1'b0;
  reg offs = 1'b0, cap = 1'b0, alt = 1'b0;
  reg [7:0] trip_at = 8'hC8;
  integer seed = 32'hff43e597;
  integer err_count = 0, num_checks = 0, cyc = 0, n, hi, mx, bon, bov;
  reg [15:0] exq[$];
  reg [15:0] e;
  wire pin, trip, bg, fg, bc, fc, br, fs, fr, sg;
  wire [7:0] outs = {bg, fg, bc, fc, br, fs, fr, sg};
  pfc_pwm_timing_protection #(.BROWNOUT_CYCLES(25'h14),
    .SAG_CYCLES(25'h0A)) u_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_timing_network_pin(pin),
    .i_boost_mod_on(mod_on), .i_boost_current_sense_low(ilim),
    .i_line_rms_sense_low(rlow), .i_line_rms_sense_high(rhigh),
    .i_line_rms_sense_sag(rsag), .i_boost_feedback_off(fboff),
    .i_bulk_good_comparator(good), .i_soft_start_release(ssr),
    .i_forward_feedback_above_offset(offs), .i_forward_current_cap(cap),
    .i_forward_mod_trip(trip), .i_alt_variant(alt), .o_boost_gate(bg),
    .o_forward_gate(fg), .o_boost_clk(bc), .o_forward_clk(fc),
    .o_boost_running(br), .o_forward_soft_start(fs),
    .o_forward_running(fr), .o_sag_tripped(sg));
  stage_model #(.OSC(OSC)) u_model (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_forward_gate(fg), .i_trip_at(trip_at),
    .o_timing_network_pin(pin), .o_forward_mod_trip(trip));
  always #25 i_clk = ~i_clk;
  // random boost demand keeps the boost gate toggling
  always @(posedge i_clk) mod_on <= ^$random(seed);
  task close_out;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // hang guard, runs need well under 20000 clocks
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      close_out;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("unexpected at %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  // note: mask and value of expected outputs, judged at next negedge
  task st(input [7:0] m, input [7:0] v);
    exq.push_back({m, v});
  endtask
  always @(negedge i_clk)
    while (exq.size() > 0) begin
      e = exq.pop_front();
      check({24'h0, outs & e[15:8]}, {24'h0, e[7:0]});
    end
  task wt(input integer k);
    repeat (k) @(posedge i_clk);
  endtask
  // summed forward run lengths, longest forward pulse and boost on-cycles over k clocks
  task win(input integer k);
    integer r;
    begin
      hi = 0;
      mx = 0;
      bon = 0;
      bov = 0;
      r = 0;
      repeat (k) begin
        @(negedge i_clk);
        r = (fg === 1'b1) ? r + 1 : 0;
        hi = hi + r;
        if (r > mx) mx = r;
        if (bg === 1'b1) bon = bon + 1;
        // boost must already be off when a forward pulse opens
        if (r == 1 && bg !== 1'b0) bov = bov + 1;
      end
      // hand back on a rising edge so the caller drives there
      @(posedge i_clk);
    end
  endtask
  task per(input s);
    time t0;
    begin
      if (s) begin
        @(posedge fc) t0 = $time;
        @(posedge fc);
      end else begin
        @(posedge bc) t0 = $time;
        @(posedge bc);
      end
      n = ($time - t0) / 50;
    end
  endtask
  task run(input a);
    integer k;
    begin
      wt(1);
      i_resetn <= 1'b0;
      alt <= a;
      {rhigh, good, ssr, offs, fboff, rsag} <= 6'h00;
      wt(5);
      i_resetn <= 1'b1;
      st(8'hFF, 8'h00);
      wt(2);
      {rhigh, good, offs} <= 3'h7;
      wt(12);
      st(8'h0F, 8'h0C);
      ssr <= 1'b1;
      wt(6);
      st(8'h0F, 8'h0E);
      per(0);
      check(n, 4 * OSC);
      per(1);
      check(n, (a ? 2 : 4) * OSC);
      for (k = 0; k < 2; k = k + 1) begin
        trip_at <= k ? 8'h05 : 8'hC8;
        win(12 * OSC);
        check({31'h0, hi > 0}, 32'h1);
        check({31'h0, mx <= (k ? 10 : (a ? 1 : 2) * OSC - 1)}, 32'h1);
        check({31'h0, bon > 0}, 32'h1);
        check(bov, 0);
      end
      if (!a) begin
        // each blocking cause alone must keep the forward gate low
        for (k = 0; k < 2; k = k + 1) begin
          cap <= k == 0;
          offs <= k == 0;
          wt(6);
          win(8 * OSC);
          check(hi, 0);
        end
        {cap, offs, ilim} <= 3'h3;
        wt(6);
        st(8'h80, 8'h00);
        ilim <= 1'b0;
        rhigh <= 1'b0;
        // short dips must not add up across a clear
        for (k = 0; k < 2; k = k + 1) begin
          rlow <= 1'b1;
          wt(12);
          rlow <= 1'b0;
          wt(4);
        end
        st(8'h0A, 8'h0A);
        rlow <= 1'b1;
        wt(30);
        st(8'h0B, 8'h02);
        rlow <= 1'b0;
        wt(6);
        st(8'h08, 8'h00);
        rhigh <= 1'b1;
        wt(6);
        st(8'h08, 8'h08);
        rhigh <= 1'b0;
        for (k = 0; k < 2; k = k + 1) begin
          rsag <= 1'b1;
          wt(6);
          rsag <= 1'b0;
          wt(4);
        end
        st(8'h01, 8'h00);
        rsag <= 1'b1;
        wt(16);
        rsag <= 1'b0;
        wt(8);
        st(8'h0B, 8'h01);
        rhigh <= 1'b1;
        wt(6);
        st(8'h09, 8'h08);
        {good, fboff} <= 2'h1;
        wt(8);
        st(8'h0F, 8'h08);
        rsag <= 1'b1;
        wt(6);
        st(8'h01, 8'h01);
      end
    end
  endtask
  initial begin
    run(1'b0);
    run(1'b1);
    wt(2);
    close_out;
  end
endmodule // tb_top
